// ===== hw/ssp_device.sv
// Purpose: Device end of the serial register port
// Assumes: Link logic runs on the serial clock, register file on i_mclk
// Notes:   Host keeps the stall gap so the reply word is settled per frame
//
// What this block does
// - Chip select high: output released, clock ignored
// - Each frame is exactly sixteen clocks
// - Receive and transmit sixteen bits concurrently
// - Write frame: 1, 0, address, data
// - One write frame changes one byte
// - Read: two zeros, address, rest ignored
// - Either byte address returns whole register
// - Read data shifts out next frame
// - Registers sixteen bits, two addressable bytes
// - Writes touch only the working copy
// - Flash update command alone persists settings
// - Reset recovery reloads working copy from flash
// - Converter result: twelve-bit straight binary register
// - Host may overlap next command with result
// - First bit at select fall, then after falls
// - Clock idles high, input sampled rising
// - Host leaves stall time between frames
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_device #(
  parameter int REGS = `SSP_REG_COUNT
) (
  input  wire logic                         i_mclk,
  input  wire logic                         i_reset_n,
  input  wire logic                         i_por_n,
  input  wire logic                         i_ce,
  input  wire logic [`SSP_AUX_W-1:0]        i_aux_adc,
  output logic                              o_ready,
  ssp_spi_if.dev                            spi
);
  import ssp_pkg::*;

  // ---------------- Link domain (serial clock) ----------------
  logic       link_clr;
  logic [3:0] rise_cnt;
  logic [3:0] fall_cnt;
  logic [14:0] rx_shift;
  ssp_word_t  rx_word;
  logic       frame_tgl;
  ssp_word_t  reply;

  assign link_clr = spi.cs_n | ~i_reset_n;

  always_ff @(posedge spi.sclk or posedge link_clr) begin
    if (link_clr) begin
      rise_cnt <= 4'h0;
    end else begin
      rise_cnt <= rise_cnt + 4'h1;
    end
  end

  always_ff @(posedge spi.sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_shift <= 15'h0000;
    end else if (!spi.cs_n) begin
      rx_shift <= {rx_shift[13:0], spi.din};
    end
  end

  always_ff @(posedge spi.sclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rx_word   <= `SSP_REG_RESET;
      frame_tgl <= 1'b0;
    end else if (!spi.cs_n && rise_cnt == 4'(`SSP_FRAME_BITS - 1)) begin
      rx_word   <= {rx_shift, spi.din};
      frame_tgl <= ~frame_tgl;
    end
  end

  // Output index follows rises seen at each fall
  always_ff @(negedge spi.sclk or posedge link_clr) begin
    if (link_clr) begin
      fall_cnt <= 4'h0;
    end else begin
      fall_cnt <= rise_cnt;
    end
  end

  assign spi.dout_o    = reply[4'hF - fall_cnt];
  assign spi.dout_oe_n = link_clr;

  // ---------------- Controller domain (i_mclk) ----------------
  logic           tgl_s1;
  logic           tgl_s2;
  logic           tgl_s3;
  logic           tgl_seen;
  logic           frame_new;
  ssp_dev_state_t state;
  ssp_idx_t       walk_idx;
  ssp_word_t      sram [REGS];
  ssp_word_t      flash_rd;
  logic           flash_wr;
  ssp_word_t      cmd;
  ssp_addr_t      cmd_addr;
  ssp_idx_t       cmd_idx;
  ssp_word_t      aux_word;
  logic           is_write;
  logic           is_read;
  logic           want_flush;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else if (i_ce) begin
      tgl_s1 <= frame_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign frame_new = (tgl_s2 == tgl_s3) && (tgl_s3 != tgl_seen) && (state == DS_RUN);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tgl_seen <= 1'b0;
    end else if (i_ce && frame_new) begin
      tgl_seen <= tgl_s3;
    end
  end

  // Word is stable for fifteen serial clocks after the toggle
  assign cmd      = rx_word;
  assign cmd_addr = cmd[`SSP_ADDR_HI:`SSP_ADDR_LO];
  assign cmd_idx  = ssp_reg_idx(cmd_addr);
  assign is_write = cmd[`SSP_WR_BIT] && !cmd[`SSP_RD_BIT];
  // Read marked 0 then 0, data bits ignored
  assign is_read  = !cmd[`SSP_WR_BIT] && !cmd[`SSP_RD_BIT];
  assign want_flush = is_write && cmd_addr == `SSP_CMD_ADDR && cmd[`SSP_FLASH_BIT];

  assign aux_word = {{(16 - `SSP_AUX_W){1'b0}}, i_aux_adc};

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state    <= DS_LOAD;
      walk_idx <= 5'h00;
    end else if (i_ce) begin
      unique case (state)
        DS_LOAD: begin
          walk_idx <= walk_idx + 5'h01;
          if (walk_idx == 5'(REGS - 1)) begin
            state <= DS_RUN;
          end
        end
        DS_RUN: begin
          walk_idx <= 5'h00;
          if (frame_new && want_flush) begin
            state <= DS_FLUSH;
          end
        end
        DS_FLUSH: begin
          walk_idx <= walk_idx + 5'h01;
          if (walk_idx == 5'(REGS - 1)) begin
            state <= DS_RUN;
          end
        end
        default: begin
          state <= DS_LOAD;
        end
      endcase
    end
  end

  assign flash_wr = (state == DS_FLUSH);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < REGS; i++) begin
        sram[i] <= `SSP_REG_RESET;
      end
    end else if (i_ce) begin
      if (state == DS_LOAD) begin
        sram[walk_idx] <= flash_rd;
      end else if (frame_new && is_write && !want_flush) begin
        if (cmd_addr[0]) begin
          sram[cmd_idx][15:8] <= cmd[7:0];
        end else begin
          sram[cmd_idx][7:0] <= cmd[7:0];
        end
      end
    end
  end

  // Reply changes after the sixteenth rise of a frame, before the next frame, while select is still low in the last clock high half
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      reply <= `SSP_REPLY_IDLE;
    end else if (i_ce && frame_new) begin
      if (is_read && cmd_idx == ssp_reg_idx(`SSP_AUX_ADDR)) begin
        reply <= aux_word;
      end else if (is_read) begin
        reply <= sram[cmd_idx];
      end else begin
        reply <= `SSP_REPLY_IDLE;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ready <= 1'b0;
    end else if (i_ce) begin
      o_ready <= (state == DS_RUN);
    end
  end

  ssp_flash_store #(
    .DEPTH (REGS)
  ) u_flash (
    .i_mclk    (i_mclk),
    .i_por_n   (i_por_n),
    .i_ce      (i_ce),
    .i_wr_en   (flash_wr),
    .i_wr_idx  (walk_idx),
    .i_wr_data (sram[walk_idx]),
    .i_rd_idx  (walk_idx),
    .o_rd_data (flash_rd)
  );
endmodule : ssp_device

// ===== common/ssp_defines.svh
// Purpose: Shared constants for the serial register port, both ends
// Assumes: 200 MHz controller clock
// Notes:   Times are in ns, cycle counts derive from them
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH

`define SSP_FRAME_BITS   16
`define SSP_WR_BIT       15
`define SSP_RD_BIT       14
`define SSP_ADDR_HI      13
`define SSP_ADDR_LO      8
`define SSP_ADDR_W       6
`define SSP_REG_COUNT    32
`define SSP_REG_RESET    16'h0000
`define SSP_REPLY_IDLE   16'h0000
`define SSP_CMD_ADDR     6'h3E
`define SSP_FLASH_BIT    3
`define SSP_AUX_ADDR     6'h16
`define SSP_AUX_W        12

`define SSP_MCLK_MHZ     200
// Least stall between frames in fast mode
`define SSP_STALL_NS     9000
`define SSP_STALL_CYC    (((`SSP_STALL_NS * `SSP_MCLK_MHZ) + 999) / 1000)
// Half period of the generated serial clock (2 MHz)
`define SSP_HALF_NS      250
`define SSP_HALF_CYC     (((`SSP_HALF_NS * `SSP_MCLK_MHZ) + 999) / 1000)

`endif

// ===== common/ssp_pkg.sv
// Purpose: Types shared by both ends of the serial register port
// Assumes: Constants come from ssp_defines.svh
// Notes:   Register index is the byte address without its byte bit
package ssp_pkg;

  typedef logic [15:0] ssp_word_t;
  typedef logic [5:0]  ssp_addr_t;
  typedef logic [4:0]  ssp_idx_t;

  typedef enum logic [1:0] {
    DS_LOAD  = 2'b00,
    DS_RUN   = 2'b01,
    DS_FLUSH = 2'b10
  } ssp_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_LEAD  = 3'b001,
    HS_LOW   = 3'b010,
    HS_HIGH  = 3'b011,
    HS_STALL = 3'b100
  } ssp_host_state_t;

  function automatic ssp_idx_t ssp_reg_idx(input ssp_addr_t addr);
    ssp_reg_idx = addr[5:1];
  endfunction : ssp_reg_idx

endpackage : ssp_pkg

// ===== common/ssp_spi_if.sv
// Purpose: Four-wire serial link between host and device
// Assumes: Data output released line reads high (pull-up)
// Notes:   Output enable is active low
`timescale 1ns/10ps
interface ssp_spi_if;
  logic cs_n;
  logic sclk;
  logic din;
  logic dout_o;
  logic dout_oe_n;
  logic dout;

  // Released line is pulled high
  assign dout = dout_oe_n ? 1'b1 : dout_o;

  modport dev (
    input  cs_n,
    input  sclk,
    input  din,
    output dout_o,
    output dout_oe_n
  );

  modport host (
    output cs_n,
    output sclk,
    output din,
    input  dout
  );
endinterface : ssp_spi_if

// ===== hw/ssp_flash_store.sv
// Purpose: Nonvolatile copy of the working registers
// Assumes: Cleared only by power-on reset, never by ordinary reset
// Notes:   Read is combinational, write one word per cycle
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_flash_store #(
  parameter int DEPTH = `SSP_REG_COUNT
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_por_n,
  input  wire logic                 i_ce,
  input  wire logic                 i_wr_en,
  input  wire ssp_pkg::ssp_idx_t    i_wr_idx,
  input  wire ssp_pkg::ssp_word_t   i_wr_data,
  input  wire ssp_pkg::ssp_idx_t    i_rd_idx,
  output ssp_pkg::ssp_word_t        o_rd_data
);
  import ssp_pkg::*;

  ssp_word_t store [DEPTH];

  always_ff @(posedge i_mclk or negedge i_por_n) begin
    if (!i_por_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        store[i] <= `SSP_REG_RESET;
      end
    end else if (i_ce && i_wr_en) begin
      store[i_wr_idx] <= i_wr_data;
    end
  end

  assign o_rd_data = store[i_rd_idx];
endmodule : ssp_flash_store

// ===== hw/ssp_host.sv
// Purpose: Host end: issues sixteen-clock frames and collects replies
// Assumes: Device output settles well within a half clock period
// Notes:   Reply of each frame belongs to the previous command
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_host #(
  parameter int HALF_CYC  = `SSP_HALF_CYC,
  parameter int STALL_CYC = `SSP_STALL_CYC
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset_n,
  input  wire logic                 i_ce,
  input  wire logic                 i_req,
  input  wire logic                 i_write,
  input  wire ssp_pkg::ssp_addr_t   i_addr,
  input  wire logic [7:0]           i_wdata,
  output logic                      o_busy,
  output logic                      o_done,
  output ssp_pkg::ssp_word_t        o_rdata,
  ssp_spi_if.host                   spi
);
  import ssp_pkg::*;

  ssp_host_state_t state;
  logic [11:0]     cnt;
  logic [4:0]      bits;
  ssp_word_t       tx;
  ssp_word_t       rx;
  logic            cs_n;
  logic            sclk;
  logic            din;
  logic            do_s1;
  logic            do_s2;
  logic            do_s3;
  logic            do_q;
  ssp_word_t       word;

  // Read: 0, 0, address, don't care
  assign word = i_write ? {2'b10, i_addr, i_wdata} : {2'b00, i_addr, 8'h00};

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      do_s1 <= 1'b1;
      do_s2 <= 1'b1;
      do_s3 <= 1'b1;
      do_q  <= 1'b1;
    end else if (i_ce) begin
      do_s1 <= spi.dout;
      do_s2 <= do_s1;
      do_s3 <= do_s2;
      if (do_s2 == do_s3) begin
        do_q <= do_s3;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state  <= HS_IDLE;
      cnt    <= 12'h000;
      bits   <= 5'h00;
      tx     <= 16'h0000;
      rx     <= 16'h0000;
      cs_n   <= 1'b1;
      sclk   <= 1'b1;
      din    <= 1'b0;
      o_done <= 1'b0;
      o_busy <= 1'b0;
      o_rdata <= 16'h0000;
    end else if (i_ce) begin
      o_done <= 1'b0;
      cnt    <= cnt + 12'h001;
      unique case (state)
        HS_IDLE: begin
          cnt <= 12'h000;
          if (i_req) begin
            tx     <= word;
            din    <= word[15];
            cs_n   <= 1'b0;
            bits   <= 5'h00;
            o_busy <= 1'b1;
            state  <= HS_LEAD;
          end
        end
        HS_LEAD: begin
          if (cnt == 12'(HALF_CYC - 1)) begin
            cnt   <= 12'h000;
            sclk  <= 1'b0;
            state <= HS_LOW;
          end
        end
        HS_LOW: begin
          if (cnt == 12'(HALF_CYC - 1)) begin
            cnt   <= 12'h000;
            sclk  <= 1'b1;
            rx    <= {rx[14:0], do_q};
            bits  <= bits + 5'h01;
            state <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (cnt == 12'(HALF_CYC - 1)) begin
            cnt <= 12'h000;
            if (bits == 5'(`SSP_FRAME_BITS)) begin
              cs_n    <= 1'b1;
              o_rdata <= rx;
              o_done  <= 1'b1;
              state   <= HS_STALL;
            end else begin
              sclk  <= 1'b0;
              din   <= tx[14];
              tx    <= {tx[14:0], 1'b0};
              state <= HS_LOW;
            end
          end
        end
        HS_STALL: begin
          if (cnt == 12'(STALL_CYC - 1)) begin
            o_busy <= 1'b0;
            state  <= HS_IDLE;
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

  assign spi.cs_n = cs_n;
  assign spi.sclk = sclk;
  assign spi.din  = din;
endmodule : ssp_host

// ===== bench/ssp_link_monitor.sv
// Purpose: Concurrent checks on the serial link between host and device
// Assumes: Host half period of 8 controller cycles, stall of 20
// Notes:   Link edges are seen through the controller clock
`timescale 1ns/10ps
module ssp_link_monitor (
  input  wire logic i_mclk,
  input  wire logic i_reset_n,
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic din,
  input  wire logic dout_o,
  input  wire logic dout_oe_n,
  input  wire logic dout
);
  logic       sclk_q;
  logic [4:0] rise_cnt;
  logic [4:0] fall_cnt;

  default clocking mon_cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= sclk;
    end
  end

  // Edge counts per frame, cleared while deselected
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rise_cnt <= 5'h00;
      fall_cnt <= 5'h00;
    end else if (cs_n) begin
      rise_cnt <= 5'h00;
      fall_cnt <= 5'h00;
    end else begin
      rise_cnt <= rise_cnt + {4'h0, sclk & ~sclk_q};
      fall_cnt <= fall_cnt + {4'h0, ~sclk & sclk_q};
    end
  end

  a_release_idle: assert property (cs_n |-> dout_oe_n)
    else $error("data output driven while deselected");
  a_drive_frame: assert property (!cs_n |-> !dout_oe_n)
    else $error("data output released inside a frame");
  a_clock_idle: assert property (cs_n |-> sclk)
    else $error("serial clock low while deselected");
  a_select_setup: assert property ($fell(cs_n) |-> sclk [*8])
    else $error("serial clock fell too soon after select");
  a_sixteen_falls: assert property ($rose(cs_n) |-> fall_cnt == 5'h10)
    else $error("frame did not hold sixteen clock falls");
  a_sixteen_rises: assert property ($rose(cs_n) |-> rise_cnt == 5'h10)
    else $error("frame did not hold sixteen sampling edges");
  a_frame_bound: assert property ($fell(cs_n) |-> ##[1:300] $rose(cs_n))
    else $error("frame did not close in time");
  a_dout_steady: assert property (
    !cs_n && !$past(cs_n) && sclk && $past(sclk) && rise_cnt < 5'h10 |-> $stable(dout))
    else $error("data output moved while clock high");
  a_din_steady: assert property (
    !cs_n && !$past(cs_n) && sclk && $past(sclk) |-> $stable(din))
    else $error("data input moved while clock high");
  a_stall_gap: assert property ($rose(cs_n) |-> cs_n [*8])
    else $error("next frame started without a stall");

  c_frame_end: cover property ($rose(cs_n));
  c_dout_low:  cover property (!cs_n && !dout);
  c_write_cmd: cover property ($fell(cs_n) && din);
  c_drive_low: cover property (!dout_oe_n && !dout_o);
endmodule : ssp_link_monitor

// ===== bench/ssp_bench.sv
// Purpose: Host and device joined by the link, driven from the host user side
// Assumes: Short half period and stall so the run stays brief
// Notes:   Link words are also captured on the wire and compared
`timescale 1ns/10ps
module ssp_bench;
  import ssp_pkg::*;
  logic        i_mclk;
  logic        i_reset_n;
  logic        i_por_n;
  logic        ce;
  logic [11:0] aux_adc;
  logic        ready;
  logic        req;
  logic        wr;
  ssp_addr_t   addr;
  logic [7:0]  wdata;
  logic        busy;
  logic        done;
  ssp_word_t   rdata;
  ssp_word_t   din_sr;
  ssp_word_t   dout_sr;
  int          error_cnt;
  int          checked;

  ssp_spi_if spi ();

  ssp_device u_ssp_device (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_por_n(i_por_n),
    .i_ce(ce), .i_aux_adc(aux_adc), .o_ready(ready), .spi(spi));

  ssp_host #(.HALF_CYC(8), .STALL_CYC(20)) u_ssp_host (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_ce(ce), .i_req(req), .i_write(wr), .i_addr(addr),
    .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_rdata(rdata), .spi(spi));

  ssp_link_monitor u_ssp_link_monitor (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .cs_n(spi.cs_n), .sclk(spi.sclk), .din(spi.din), .dout_o(spi.dout_o),
    .dout_oe_n(spi.dout_oe_n), .dout(spi.dout));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  // Both lines captured on the rising serial clock, where the device samples din and the host samples dout
  always @(posedge spi.sclk) begin
    if (!spi.cs_n) begin
      din_sr <= {din_sr[14:0], spi.din};
      dout_sr <= {dout_sr[14:0], spi.dout};
    end
  end

  task automatic test_done();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic chk(input ssp_word_t got, input ssp_word_t exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  function automatic logic pick(input int k);
    return (k == 0) ? ready : ((k == 1) ? done : busy);
  endfunction : pick

  task automatic wait_lvl(input int k, input logic lvl);
    int n;
    n = 0;
    while (pick(k) !== lvl) begin
      @(negedge i_mclk);
      n++;
      if (n > 400) begin
        error_cnt++;
        $display("BAD t=%0t wait limit on %0d", $time, k);
        test_done();
      end
    end
  endtask : wait_lvl

  task automatic do_reset();
    @(posedge i_mclk);
    i_reset_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    i_por_n <= 1'b1;
  endtask : do_reset

  // One frame; exp is the reply owed to the previous command
  task automatic xfer(input logic w, input ssp_addr_t a, input logic [7:0] d,
                      input ssp_word_t exp);
    wait_lvl(0, 1'b1);
    @(posedge i_mclk);
    req <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge i_mclk);
    req <= 1'b0;
    wait_lvl(1, 1'b1);
    chk(rdata, exp, "reply word");
    chk(dout_sr, exp, "reply bits");
    if (w) begin
      chk(din_sr, {2'b10, a, d}, "write bits");
    end else begin
      chk({din_sr[15:8], 8'h00}, {2'b00, a, 8'h00}, "read bits");
    end
    wait_lvl(2, 1'b0);
  endtask : xfer

  initial begin
    error_cnt = 0;
    checked = 0;
    i_reset_n = 1'b0;
    i_por_n = 1'b0;
    ce = 1'b1;
    aux_adc = 12'hFFF;
    req = 1'b0;
    wr = 1'b0;
    addr = 6'h00;
    wdata = 8'h00;
    do_reset();
    xfer(1'b1, 6'h05, 8'hA5, 16'h0000);
    xfer(1'b1, 6'h04, 8'h3C, 16'h0000);
    xfer(1'b0, 6'h05, 8'hFF, 16'h0000);
    xfer(1'b0, 6'h04, 8'hFF, 16'hA53C);
    xfer(1'b1, 6'h04, 8'h11, 16'hA53C);
    xfer(1'b0, 6'h05, 8'hFF, 16'h0000);
    xfer(1'b0, 6'h16, 8'hFF, 16'hA511);
    @(posedge i_mclk);
    aux_adc <= 12'h5A3;
    xfer(1'b0, 6'h17, 8'hFF, 16'h0FFF);
    xfer(1'b1, 6'h06, 8'h77, 16'h05A3);
    xfer(1'b1, 6'h3E, 8'h08, 16'h0000);
    xfer(1'b1, 6'h06, 8'h99, 16'h0000);
    xfer(1'b0, 6'h06, 8'hFF, 16'h0000);
    xfer(1'b0, 6'h04, 8'hFF, 16'h0099);
    do_reset();
    // Reload must stall while the clock enable is low
    ce <= 1'b0;
    repeat (40) @(posedge i_mclk);
    @(negedge i_mclk);
    chk({15'h0000, ready}, 16'h0000, "ready while frozen");
    @(posedge i_mclk);
    ce <= 1'b1;
    xfer(1'b0, 6'h06, 8'hFF, 16'h0000);
    xfer(1'b0, 6'h05, 8'hFF, 16'h0077);
    xfer(1'b0, 6'h00, 8'hFF, 16'hA511);
    test_done();
  end
endmodule : ssp_bench
